/* smva_pkg.sv */
// Purpose: Shared constants and types for the sparse matrix-vector engine.
// Assumes: Both ends run on the same core clock.
// Notes:   The state encoding is Gray along load, compute and send.
package smva_pkg;

  // ==========================================================================
  // Sizes
  localparam int N  = 3;
  localparam int DW = 8;
  localparam int IW = 2;
  localparam int SW = 10;
  localparam int EW = 4;

  // ==========================================================================
  // Values
  localparam logic [DW-1:0] SAT_MAX   = 8'hff;
  localparam logic [IW-1:0] IDX_FIRST = 2'h0;
  localparam logic [IW-1:0] IDX_LAST  = 2'h2;
  localparam logic [EW-1:0] ENT_ZERO  = 4'h0;
  localparam logic [EW-1:0] ENT_ONE   = 4'h1;

  // ==========================================================================
  // Device sequencer states
  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_COMP = 2'h1,
    ST_SEND = 2'h3
  } smva_state_t;

  typedef logic [N-1:0][DW-1:0] smva_vec_t;

endpackage

/* smva_if.sv */
// Purpose: Link between the loading host and the matrix-vector engine.
// Assumes: One shared clock; all link signals are plain logic levels.
// Notes:   Strobe and done come from the host, the flags from the engine.
`timescale 1ns/1ns
interface smva_if (
  input wire logic core_clk
);
  import smva_pkg::*;

  logic [DW-1:0] val;
  logic [IW-1:0] col;
  logic [IW-1:0] row;
  logic          strobe;
  logic          done;
  logic          fetch;
  logic          flag;
  logic [DW-1:0] res;

  modport dev (
    input  val,
    input  col,
    input  row,
    input  strobe,
    input  done,
    output fetch,
    output flag,
    output res
  );

  modport hst (
    output val,
    output col,
    output row,
    output strobe,
    output done,
    input  fetch,
    input  flag,
    input  res
  );

endinterface

/* smva_dev.sv */
// Purpose: Sparse 3x3 weight matrix times 3-bit spike vector engine.
// Assumes: Host shares core_clk, so link inputs need no synchroniser.
// Notes:   Results saturate at the largest 8-bit value.
//
// Operation
// - Take 3x3 matrix of 8-bit weights.
// - Take 3-bit spike train as multiplicand.
// - Entries arrive singly, stored internally.
// - Compute as soon as spikes loaded, however many entries came first.
// - Present each result, invert result flag.
// - Host strobes one cycle, entry held steady.
// - Host drops strobe between successive entries.
// - Remaining two results follow on consecutive edges.
// - Engine drives fetch and result flags.
`timescale 1ns/1ns
module smva_dev (
  input  wire logic               core_clk,
  input  wire logic               rst,
  smva_if.dev                     lnk,
  output      smva_pkg::smva_vec_t usr_res,
  output      logic               usr_res_vld,
  output      logic [smva_pkg::EW-1:0] usr_entries,
  output      logic               usr_busy
);
  import smva_pkg::*;

  // ==========================================================================
  // State

  typedef struct packed {
    smva_state_t             st;
    logic [N*N-1:0][DW-1:0]  w;
    logic [N-1:0]            spike;
    logic                    stb_d;
    logic [IW-1:0]           idx;
    smva_vec_t               res;
    logic [DW-1:0]           out;
    logic                    flag;
    logic                    fetch;
    logic [EW-1:0]           ents;
    logic                    vld;
    logic                    busy;
  } smva_dev_t;

  smva_dev_t q;
  smva_dev_t d;

  // ==========================================================================
  // Entry decode

  logic          take;
  logic          idx_ok;
  logic [EW-1:0] ent;

  // Only a rising strobe counts, so a host that holds it high for longer
  // still loads one entry instead of rewriting it every cycle.
  assign take   = lnk.strobe && !q.stb_d;
  assign idx_ok = (lnk.row < IW'(N)) && (lnk.col < IW'(N));
  assign ent    = EW'(lnk.row) * EW'(N) + EW'(lnk.col);

  // ==========================================================================
  // Row sums

  smva_vec_t row_sum;

  for (genvar i = 0; i < N; i++) begin : g_row
    logic [SW-1:0] acc;

    always_comb begin
      acc = '0;
      for (int j = 0; j < N; j++) begin
        if (q.spike[j]) begin
          acc = acc + SW'(q.w[i*N+j]);
        end
      end
    end

    // Saturation keeps a large dot product from wrapping to a small one.
    assign row_sum[i] = (acc > SW'(SAT_MAX)) ? SAT_MAX : acc[DW-1:0];
  end

  // ==========================================================================
  // Sequencer

  always_comb begin
    d       = q;
    d.stb_d = lnk.strobe;
    d.vld   = 1'b0;
    case (q.st)
      ST_LOAD: begin
        d.fetch = 1'b1;
        d.busy  = 1'b0;
        if (take) begin
          if (lnk.done) begin
            // The done marker carries the spike train and closes loading.
            d.spike = lnk.val[N-1:0];
            d.st    = ST_COMP;
            d.fetch = 1'b0;
            d.busy  = 1'b1;
          end else if (idx_ok) begin
            d.w[ent] = lnk.val;
            d.ents   = q.ents + ENT_ONE;
          end
        end
      end
      ST_COMP: begin
        d.res = row_sum;
        d.idx = IDX_FIRST;
        d.st  = ST_SEND;
      end
      ST_SEND: begin
        d.out  = q.res[q.idx];
        d.flag = ~q.flag;
        d.idx  = q.idx + 1'b1;
        if (q.idx == IDX_LAST) begin
          // Clearing here makes entries left out of the next load read zero.
          d.st    = ST_LOAD;
          d.w     = '0;
          d.spike = '0;
          d.ents  = ENT_ZERO;
          d.vld   = 1'b1;
          // Fetch comes back with the last result, so the host may load the
          // next matrix as soon as it has captured the third value.
          d.fetch = 1'b1;
          d.busy  = 1'b0;
        end
      end
      default: begin
        d = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs

  assign lnk.fetch   = q.fetch;
  assign lnk.flag    = q.flag;
  assign lnk.res     = q.out;
  assign usr_res     = q.res;
  assign usr_res_vld = q.vld;
  assign usr_entries = q.ents;
  assign usr_busy    = q.busy;

endmodule

/* smva_host.sv */
// Purpose: Host end that loads entries and spikes and gathers results.
// Assumes: Engine shares core_clk, so link inputs need no synchroniser.
// Notes:   Requests made while busy or before fetch is up are dropped.
`timescale 1ns/1ns
module smva_host (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  smva_if.hst                         lnk,
  input  wire logic                   usr_wr,
  input  wire logic [smva_pkg::DW-1:0] usr_val,
  input  wire logic [smva_pkg::IW-1:0] usr_col,
  input  wire logic [smva_pkg::IW-1:0] usr_row,
  input  wire logic                   usr_spike_wr,
  input  wire logic [smva_pkg::N-1:0]  usr_spike,
  output      logic                   usr_busy,
  output      smva_pkg::smva_vec_t     usr_res,
  output      logic                   usr_res_vld
);
  import smva_pkg::*;

  // ==========================================================================
  // State

  typedef struct packed {
    logic          stb;
    logic          gap;
    logic          done;
    logic          wt;
    logic [DW-1:0] val;
    logic [IW-1:0] col;
    logic [IW-1:0] row;
    logic          prev_flag;
    logic [IW-1:0] cnt;
    smva_vec_t     res;
    logic          vld;
    logic          busy;
  } smva_host_t;

  smva_host_t q;
  smva_host_t d;

  // ==========================================================================
  // Sender and collector

  always_comb begin
    d           = q;
    d.vld       = 1'b0;
    d.prev_flag = lnk.flag;
    if (q.stb) begin
      d.stb = 1'b0;
      d.gap = 1'b1;
    end else if (q.gap) begin
      d.gap  = 1'b0;
      d.done = 1'b0;
    end else if (!q.wt && lnk.fetch && (usr_wr || usr_spike_wr)) begin
      d.stb  = 1'b1;
      d.done = usr_spike_wr;
      d.wt   = usr_spike_wr;
      d.val  = usr_spike_wr ? DW'(usr_spike) : usr_val;
      d.col  = usr_col;
      d.row  = usr_row;
    end
    // Nothing is captured until the flag has first moved.
    if (lnk.flag != q.prev_flag) begin
      d.res[q.cnt] = lnk.res;
      d.cnt        = q.cnt + 1'b1;
      if (q.cnt == IDX_LAST) begin
        d.cnt = IDX_FIRST;
        d.vld = 1'b1;
        d.wt  = 1'b0;
      end
    end
    d.busy = d.stb || d.gap || d.wt;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs

  assign lnk.strobe  = q.stb;
  assign lnk.done    = q.done;
  assign lnk.val     = q.val;
  assign lnk.col     = q.col;
  assign lnk.row     = q.row;
  assign usr_busy    = q.busy;
  assign usr_res     = q.res;
  assign usr_res_vld = q.vld;

endmodule

/* smva_assertions.sv */
// Purpose: Timing checks on the link between host and engine.
// Assumes: One clock; rst is asynchronous and active high.
// Notes:   Cycle figures follow the agreed link walk.
`timescale 1ns/1ns
module smva_assertions (
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire logic                   strobe,
  input wire logic                   done,
  input wire logic                   fetch,
  input wire logic                   flag,
  input wire logic [smva_pkg::DW-1:0] res
);
  import smva_pkg::*;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // Spike train taken
  sequence spk;
    $rose(strobe) && done && fetch;
  endsequence

  a_fetch_drop: assert property (spk |=> !fetch [*4] ##1 fetch)
    else $error("fetch not low for four cycles after spikes");
  a_flag_burst: assert property (spk |=> $stable(flag) [*2] ##1
    $changed(flag) [*3])
    else $error("result flag did not toggle three times in a row");
  a_flag_quiet: assert property ($changed(flag) |-> !$past(fetch))
    else $error("result flag moved while loading");
  a_res_flag: assert property (!$changed(flag) |-> $stable(res))
    else $error("result changed without a flag toggle");
  a_entry_keep: assert property ($rose(strobe) && !done && fetch
    |=> fetch && $stable(flag))
    else $error("entry load started a computation");
  a_no_early: assert property ($fell(fetch) |-> $stable(res) [*2])
    else $error("result appeared before compute");
  a_fetch_rise: assert property ($rose(fetch) |-> $changed(flag) ||
    $past(rst, 2))
    else $error("fetch rose apart from the last result");
  a_rst_clear: assert property (disable iff (1'b0)
    rst |-> !fetch && !flag && res == 8'h00)
    else $error("link outputs not cleared in reset");
endmodule

/* tb.sv */
// Purpose: Self-checking bench for host and engine joined by the link.
// Assumes: Both ends share core_clk at 10 MHz.
// Notes:   Weights, indices and spikes come from a fixed seed.
`timescale 1ns/1ns
module tb;
  import smva_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst      = 1'b0;
  logic       wr       = 1'b0;
  logic [7:0] v        = 8'h00;
  logic [1:0] c        = 2'h0;
  logic [1:0] r        = 2'h0;
  logic       swr      = 1'b0;
  logic [2:0] sp       = 3'h0;
  logic       hbusy;
  logic       hvld;
  logic [3:0] dent;
  smva_vec_t  hres;
  smva_vec_t  dres;
  int         n_fail   = 0;
  int         compares = 0;
  int         seed     = 41934;
  int         m[9];
  int         nent;

  always #50 core_clk = ~core_clk;

  smva_if lnk (.core_clk(core_clk));
  smva_dev i_smva_dev (.core_clk(core_clk), .rst(rst), .lnk(lnk),
    .usr_res(dres), .usr_res_vld(), .usr_entries(dent), .usr_busy());
  smva_host i_smva_host (.core_clk(core_clk), .rst(rst), .lnk(lnk),
    .usr_wr(wr), .usr_val(v), .usr_col(c), .usr_row(r),
    .usr_spike_wr(swr), .usr_spike(sp), .usr_busy(hbusy),
    .usr_res(hres), .usr_res_vld(hvld));
  smva_assertions u_chk (.core_clk(core_clk), .rst(rst),
    .strobe(lnk.strobe), .done(lnk.done), .fetch(lnk.fetch),
    .flag(lnk.flag), .res(lnk.res));

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bounded so a stuck host still reaches the comparisons.
  task automatic idle;
    for (int k = 0; k < 50 && (hbusy !== 1'b0 || lnk.fetch !== 1'b1); k++)
      @(negedge core_clk);
  endtask

  task automatic put(input int col, input int row, input logic [7:0] val);
    idle();
    wr = 1'b1;
    v = val;
    c = col[1:0];
    r = row[1:0];
    @(negedge core_clk);
    wr = 1'b0;
    if (col < 3 && row < 3) begin
      m[row*3+col] = val;
      nent++;
    end
  endtask

  task automatic do_rst(input int n);
    rst = 1'b1;
    repeat (n) @(negedge core_clk);
    chk(24'({lnk.flag, lnk.fetch, dent}), 24'h0);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic round(input int nw);
    logic [23:0] e;
    int          s;
    int          d0;
    idle();
    d0 = dent;
    nent = 0;
    for (int i = 0; i < 9; i++)
      m[i] = 0;
    for (int i = 0; i < nw; i++)
      put($random(seed) & 3, $random(seed) & 3, 8'($random(seed)));
    idle();
    chk(24'(dent), 24'(4'(d0 + nent)));
    s = $random(seed) & 7;
    swr = 1'b1;
    sp = s[2:0];
    @(negedge core_clk);
    swr = 1'b0;
    for (int i = 0; i < 3; i++) begin
      int a;
      a = 0;
      for (int j = 0; j < 3; j++)
        if (s[j])
          a += m[i*3+j];
      e[i*8 +: 8] = (a > 255) ? 8'hff : 8'(a);
    end
    for (int k = 0; k < 20 && hvld !== 1'b1; k++)
      @(negedge core_clk);
    chk(hres, e);
    chk(dres, e);
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    // A real rising edge on rst, so the asynchronous reset is seen.
    #1;
    do_rst(16);
    round(0);
    for (int t = 0; t < 10; t++) begin
      round(3 + t);
      $display("round %0d done", t);
    end
    put(1, 1, 8'h55);
    idle();
    do_rst(2);
    round(2);
    $display("reset round done");
    results();
  end

  initial begin
    #(100 * 5000);
    n_fail++;
    results();
  end
endmodule
